/* File: verilog/mac_hash_consts.svh */
`ifndef MAC_HASH_CONSTS_SVH
`define MAC_HASH_CONSTS_SVH

// register byte offsets, one aligned 32-bit word each
`define OFS_UNICAST_HASH_UPPER 6'h00
`define OFS_UNICAST_HASH_LOWER 6'h04
`define OFS_MULTICAST_HASH_UPPER 6'h08
`define OFS_MULTICAST_HASH_LOWER 6'h0c
`define OFS_TX_START_WATERMARK 6'h10
`define OFS_FIFO_RAM_UPPER_BOUND 6'h14
`define OFS_RX_FIFO_START_ADDR 6'h18

// field positions
`define WMRK_MSB 1
`define WMRK_LSB 0
`define RAM_ADDR_MSB 9
`define RAM_ADDR_LSB 2
`define RAM_FIXED_BIT 10

// reset values
`define RST_TX_WATERMARK 2'h0
`define RST_RX_REGION_START 8'h80
`define RST_FIFO_RAM_BOUND 8'hff

// watermark byte counts
`define WMRK_BYTES_LOW 11'h040
`define WMRK_BYTES_MID 11'h080
`define WMRK_BYTES_HIGH 11'h0c0

`endif

/* File: verilog/mac_hash_pkg.sv */
package mac_hash_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_e;

  typedef logic [1:0] tx_watermark_sel_t;
  typedef logic [7:0] ram_word_addr_t;
  typedef logic [10:0] ram_byte_addr_t;
  typedef logic [5:0] hash_index_t;

endpackage

/* File: verilog/hash_table_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface hash_table_if;
  import mac_hash_pkg::*;
  logic wr_upper;
  logic wr_lower;
  logic [31:0] wr_data;
  logic [3:0] wr_be;
  hash_index_t index;
  logic bit_out;
  logic [31:0] upper_word;
  logic [31:0] lower_word;
  modport ctrl (output wr_upper, output wr_lower, output wr_data, output wr_be, output index,
    input bit_out, input upper_word, input lower_word);
  modport table_side (input wr_upper, input wr_lower, input wr_data, input wr_be, input index,
    output bit_out, output upper_word, output lower_word);
endinterface
`default_nettype wire

/* File: verilog/hash_table.sv */
`timescale 1ns/1ps
`default_nettype none
module hash_table (
  // clock
  input wire logic clk_sys,
  // table access
  hash_table_if.table_side ht
);
  import mac_hash_pkg::*;

  // table words hold no reset value; software must load them first
  logic [31:0] upper_r;
  logic [31:0] lower_r;
  logic [63:0] table_w;

  always_ff @(posedge clk_sys) begin
    for (int b = 0; b < 4; b++) begin
      if (ht.wr_upper && ht.wr_be[b]) begin
        upper_r[b*8 +: 8] <= ht.wr_data[b*8 +: 8];
      end
      if (ht.wr_lower && ht.wr_be[b]) begin
        lower_r[b*8 +: 8] <= ht.wr_data[b*8 +: 8];
      end
    end
  end

  // upper word bit n is index n+32, lower word bit n is index n
  assign table_w = {upper_r, lower_r};
  assign ht.bit_out = table_w[ht.index];
  assign ht.upper_word = upper_r;
  assign ht.lower_word = lower_r;
endmodule
`default_nettype wire

/* File: verilog/tx_start_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module tx_start_gate #(
  parameter int LEVEL_W = 11
) (
  // watermark choice
  input wire mac_hash_pkg::tx_watermark_sel_t tx_watermark_sel,
  // fifo state
  input wire logic [LEVEL_W-1:0] tx_fifo_bytes,
  input wire logic tx_frame_whole,
  // decision
  output logic start_ok
);
  import mac_hash_pkg::*;
  `include "mac_hash_consts.svh"

  logic [LEVEL_W-1:0] threshold_w;

  // 0x selects the lowest count, so bit 0 only matters when bit 1 is set
  assign threshold_w = !tx_watermark_sel[1] ? LEVEL_W'(`WMRK_BYTES_LOW) :
                       tx_watermark_sel[0] ? LEVEL_W'(`WMRK_BYTES_HIGH) :
                       LEVEL_W'(`WMRK_BYTES_MID);
  // a short frame already complete need not wait for the watermark
  assign start_ok = (tx_fifo_bytes >= threshold_w) || tx_frame_whole;
endmodule
`default_nettype wire

/* File: verilog/mac_hash_fifo_partition_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mac_hash_consts.svh"
module mac_hash_fifo_partition_regs #(
  parameter mac_hash_pkg::ram_word_addr_t RAM_BOUND = `RST_FIFO_RAM_BOUND,
  parameter mac_hash_pkg::ram_word_addr_t RX_START_DEFAULT = `RST_RX_REGION_START,
  parameter int LEVEL_W = 11
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // receive address recognition
  input wire logic lookup_valid,
  input wire logic lookup_multicast,
  input wire mac_hash_pkg::hash_index_t lookup_index,
  output logic lookup_done,
  output logic lookup_hit,
  output logic hash_tables_loaded,
  // transmit start
  input wire logic [LEVEL_W-1:0] tx_fifo_bytes,
  input wire logic tx_frame_whole,
  output logic tx_start_ok,
  // fifo ram partition
  output mac_hash_pkg::ram_byte_addr_t tx_region_last,
  output mac_hash_pkg::ram_byte_addr_t rx_region_first,
  output mac_hash_pkg::ram_byte_addr_t rx_region_last
);
  import mac_hash_pkg::*;

  hash_table_if uc_if ();
  hash_table_if mc_if ();

  bus_state_e state_r;
  bus_state_e state_nxt;
  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic [31:0] readdata_nxt;

  tx_watermark_sel_t tx_watermark_sel_r;
  ram_word_addr_t rx_region_start_r;
  logic [3:0] words_loaded_r;
  logic hash_tables_loaded_r;

  logic lookup_done_r;
  logic lookup_hit_r;
  logic tx_start_ok_r;
  ram_byte_addr_t tx_region_last_r;
  ram_byte_addr_t rx_region_first_r;
  ram_byte_addr_t rx_region_last_r;

  // bus decode
  logic req_w;
  logic wr_commit_w;
  logic [5:0] word_ofs_w;
  logic sel_uc_hi_w;
  logic sel_uc_lo_w;
  logic sel_mc_hi_w;
  logic sel_mc_lo_w;
  logic sel_wmrk_w;
  logic sel_bound_w;
  logic sel_rxstart_w;
  logic sel_any_w;

  assign req_w = avs_read || avs_write;
  // writes land only at the edge where the master sees waitrequest low
  assign wr_commit_w = avs_write && !waitrequest_r;
  assign word_ofs_w = {avs_address[5:2], 2'b00};
  assign sel_uc_hi_w = word_ofs_w == `OFS_UNICAST_HASH_UPPER;
  assign sel_uc_lo_w = word_ofs_w == `OFS_UNICAST_HASH_LOWER;
  assign sel_mc_hi_w = word_ofs_w == `OFS_MULTICAST_HASH_UPPER;
  assign sel_mc_lo_w = word_ofs_w == `OFS_MULTICAST_HASH_LOWER;
  assign sel_wmrk_w = word_ofs_w == `OFS_TX_START_WATERMARK;
  assign sel_bound_w = word_ofs_w == `OFS_FIFO_RAM_UPPER_BOUND;
  assign sel_rxstart_w = word_ofs_w == `OFS_RX_FIFO_START_ADDR;
  assign sel_any_w = sel_uc_hi_w || sel_uc_lo_w || sel_mc_hi_w || sel_mc_lo_w
                     || sel_wmrk_w || sel_bound_w || sel_rxstart_w;

  // hash table write ports
  assign uc_if.wr_upper = wr_commit_w && sel_uc_hi_w;
  assign uc_if.wr_lower = wr_commit_w && sel_uc_lo_w;
  assign uc_if.wr_data = avs_writedata;
  assign uc_if.wr_be = avs_byteenable;
  assign uc_if.index = lookup_index;
  assign mc_if.wr_upper = wr_commit_w && sel_mc_hi_w;
  assign mc_if.wr_lower = wr_commit_w && sel_mc_lo_w;
  assign mc_if.wr_data = avs_writedata;
  assign mc_if.wr_be = avs_byteenable;
  assign mc_if.index = lookup_index;

  hash_table u_unicast_table (
    .clk_sys(clk_sys),
    .ht(uc_if.table_side)
  );

  hash_table u_multicast_table (
    .clk_sys(clk_sys),
    .ht(mc_if.table_side)
  );

  // readback views
  logic [31:0] wmrk_view_w;
  logic [31:0] bound_view_w;
  logic [31:0] rxstart_view_w;

  assign wmrk_view_w = {30'h0, tx_watermark_sel_r};
  // bound is a tie-off, so a write to it has nothing to change
  assign bound_view_w = {21'h0, 1'b1, RAM_BOUND, 2'b00};
  assign rxstart_view_w = {21'h0, 1'b1, rx_region_start_r, 2'b00};

  always_comb begin
    readdata_nxt = 32'h0;
    if (sel_uc_hi_w) begin
      readdata_nxt = uc_if.upper_word;
    end else if (sel_uc_lo_w) begin
      readdata_nxt = uc_if.lower_word;
    end else if (sel_mc_hi_w) begin
      readdata_nxt = mc_if.upper_word;
    end else if (sel_mc_lo_w) begin
      readdata_nxt = mc_if.lower_word;
    end else if (sel_wmrk_w) begin
      readdata_nxt = wmrk_view_w;
    end else if (sel_bound_w) begin
      readdata_nxt = bound_view_w;
    end else if (sel_rxstart_w) begin
      readdata_nxt = rxstart_view_w;
    end
  end

  // handshake: one idle-to-ack step per request, then back to idle
  always_comb begin
    case (state_r)
      BUS_IDLE: begin
        state_nxt = req_w ? BUS_ACK : BUS_IDLE;
      end
      BUS_ACK: begin
        state_nxt = BUS_IDLE;
      end
      default: begin
        state_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_r <= BUS_IDLE;
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      waitrequest_r <= !(state_r == BUS_IDLE && req_w);
      if (state_r == BUS_IDLE && avs_read) begin
        readdata_r <= sel_any_w ? readdata_nxt : 32'h0;
      end
    end
  end

  // unmapped addresses read zero (capture above) and swallow writes (no select)

  // watermark field; upper bits are not stored
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_watermark_sel_r <= `RST_TX_WATERMARK;
    end else if (wr_commit_w && sel_wmrk_w && avs_byteenable[0]) begin
      tx_watermark_sel_r <= avs_writedata[`WMRK_MSB:`WMRK_LSB];
    end
  end

  // receive start straddles byte lanes 0 and 1
  logic [7:0] rxstart_wdata_w;
  assign rxstart_wdata_w[5:0] = avs_byteenable[0] ? avs_writedata[7:2] : rx_region_start_r[5:0];
  assign rxstart_wdata_w[7:6] = avs_byteenable[1] ? avs_writedata[9:8] : rx_region_start_r[7:6];

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_region_start_r <= RX_START_DEFAULT;
    end else if (wr_commit_w && sel_rxstart_w) begin
      rx_region_start_r <= rxstart_wdata_w;
    end
  end

  // track which hash words software has loaded since reset
  logic [3:0] word_wr_w;
  logic tables_ready_w;
  assign word_wr_w = {mc_if.wr_lower, mc_if.wr_upper, uc_if.wr_lower, uc_if.wr_upper};
  assign tables_ready_w = &words_loaded_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      words_loaded_r <= 4'h0;
      hash_tables_loaded_r <= 1'b0;
    end else begin
      words_loaded_r <= words_loaded_r | word_wr_w;
      // flop copy for the port; rises at the same edge as the last word lands
      hash_tables_loaded_r <= &(words_loaded_r | word_wr_w);
    end
  end

  // recognition; before all four words are loaded no frame matches
  logic table_bit_w;
  assign table_bit_w = lookup_multicast ? mc_if.bit_out : uc_if.bit_out;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lookup_done_r <= 1'b0;
      lookup_hit_r <= 1'b0;
    end else begin
      lookup_done_r <= lookup_valid;
      if (lookup_valid) begin
        lookup_hit_r <= tables_ready_w && table_bit_w;
      end
    end
  end

  // transmit start decision
  logic start_ok_w;

  tx_start_gate #(
    .LEVEL_W(LEVEL_W)
  ) u_tx_start_gate (
    .tx_watermark_sel(tx_watermark_sel_r),
    .tx_fifo_bytes(tx_fifo_bytes),
    .tx_frame_whole(tx_frame_whole),
    .start_ok(start_ok_w)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_start_ok_r <= 1'b0;
    end else begin
      tx_start_ok_r <= start_ok_w;
    end
  end

  // partition byte addresses; bit 10 is always set in both receive addresses
  ram_byte_addr_t rx_first_w;
  ram_byte_addr_t rx_last_w;
  ram_byte_addr_t tx_last_w;
  assign rx_first_w = {1'b1, rx_region_start_r, 2'b00};
  assign rx_last_w = {1'b1, RAM_BOUND, 2'b00};
  // a receive start of 0 still leaves transmit bytes up to 0x3fc; bit 10 keeps the subtraction from wrapping
  assign tx_last_w = rx_first_w - 11'h004;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_region_last_r <= 11'h0;
      rx_region_first_r <= 11'h0;
      rx_region_last_r <= 11'h0;
    end else begin
      tx_region_last_r <= tx_last_w;
      rx_region_first_r <= rx_first_w;
      rx_region_last_r <= rx_last_w;
    end
  end

  assign avs_readdata = readdata_r;
  assign avs_waitrequest = waitrequest_r;
  assign lookup_done = lookup_done_r;
  assign lookup_hit = lookup_hit_r;
  assign hash_tables_loaded = hash_tables_loaded_r;
  assign tx_start_ok = tx_start_ok_r;
  assign tx_region_last = tx_region_last_r;
  assign rx_region_first = rx_region_first_r;
  assign rx_region_last = rx_region_last_r;
endmodule
`default_nettype wire

/* File: sim/mac_hash_fifo_partition_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module mac_hash_fifo_partition_regs_chk #(
  parameter logic [7:0] RAM_BOUND = 8'hff,
  parameter int LEVEL_W = 11
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // lookup
  input wire logic lookup_valid,
  input wire logic lookup_done,
  input wire logic lookup_hit,
  input wire logic hash_tables_loaded,
  // transmit start
  input wire logic [LEVEL_W-1:0] tx_fifo_bytes,
  input wire logic tx_frame_whole,
  input wire logic tx_start_ok,
  // partition
  input wire mac_hash_pkg::ram_byte_addr_t tx_region_last,
  input wire mac_hash_pkg::ram_byte_addr_t rx_region_first,
  input wire mac_hash_pkg::ram_byte_addr_t rx_region_last
);
  import mac_hash_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_req;
    lookup_valid;
  endsequence
  a_lookup_answer: assert property (s_req |=> lookup_done)
    else $error("lookup not answered");
  a_done_cause: assert property (lookup_done |-> $past(lookup_valid))
    else $error("lookup done without request");
  a_hit_gated: assert property (lookup_done && !$past(hash_tables_loaded) |-> !lookup_hit)
    else $error("hit before tables loaded");
  a_hit_holds: assert property (!lookup_done && $past(rst_b) |-> $stable(lookup_hit))
    else $error("hit changed without lookup");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write))
    else $error("answer without request");
  a_tx_whole: assert property ($past(rst_b) && $past(tx_frame_whole) |-> tx_start_ok)
    else $error("whole frame not started");
  a_tx_full: assert property ($past(rst_b) && $past(tx_fifo_bytes) >= 192 |-> tx_start_ok)
    else $error("no start above top watermark");
  a_tx_short: assert property ($past(rst_b) && $past(tx_fifo_bytes) < 64 && !$past(tx_frame_whole)
    |-> !tx_start_ok)
    else $error("start below low watermark");
  a_rx_first: assert property ($past(rst_b) |-> rx_region_first[10] && rx_region_first[1:0] == 2'h0)
    else $error("rx start fixed bits wrong");
  a_tx_end: assert property ($past(rst_b) |-> tx_region_last == rx_region_first - 11'h004)
    else $error("tx region end wrong");
  a_rx_end: assert property ($past(rst_b) |-> rx_region_last == {1'b1, RAM_BOUND, 2'h0})
    else $error("rx region end wrong");
endmodule
bind mac_hash_fifo_partition_regs mac_hash_fifo_partition_regs_chk #(.RAM_BOUND(RAM_BOUND), .LEVEL_W(LEVEL_W)) u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .lookup_valid(lookup_valid), .lookup_done(lookup_done),
  .lookup_hit(lookup_hit), .hash_tables_loaded(hash_tables_loaded), .tx_fifo_bytes(tx_fifo_bytes),
  .tx_frame_whole(tx_frame_whole), .tx_start_ok(tx_start_ok), .tx_region_last(tx_region_last),
  .rx_region_first(rx_region_first), .rx_region_last(rx_region_last));
`default_nettype wire

/* File: sim/tb_mac_hash_fifo_partition_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mac_hash_consts.svh"
module tb_mac_hash_fifo_partition_regs;
  import mac_hash_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, lookup_done, lookup_hit, hash_tables_loaded, tx_start_ok;
  logic lookup_valid = 1'b0;
  logic lookup_multicast = 1'b0;
  hash_index_t lookup_index = 6'h00;
  logic [10:0] tx_fifo_bytes = 11'h000;
  logic tx_frame_whole = 1'b0;
  ram_byte_addr_t tx_region_last, rx_region_first, rx_region_last;
  logic [63:0] uni = 64'h8000_0001_f0f0_0001;
  logic [63:0] grp = 64'h0001_8000_1234_8765;
  int thr [4] = '{64, 64, 128, 192};
  int miscompares = 0;
  int num_checks = 0;

  mac_hash_fifo_partition_regs dut (.clk_sys, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .lookup_valid,
    .lookup_multicast, .lookup_index, .lookup_done, .lookup_hit, .hash_tables_loaded,
    .tx_fifo_bytes, .tx_frame_whole, .tx_start_ok, .tx_region_last, .rx_region_first,
    .rx_region_last);

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // the request holds until waitrequest is sampled low at an edge
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk_sys iff avs_waitrequest === 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task look(input logic mc, input hash_index_t i, input logic e);
    @(posedge clk_sys);
    lookup_valid <= 1'b1;
    lookup_multicast <= mc;
    lookup_index <= i;
    @(posedge clk_sys);
    lookup_valid <= 1'b0;
    #1;
    chk("lookup_done", lookup_done, 32'h1);
    chk("lookup_hit", lookup_hit, e);
  endtask

  task tx(input logic [10:0] b, input logic w, input logic e);
    @(posedge clk_sys);
    tx_fifo_bytes <= b;
    tx_frame_whole <= w;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("tx_start_ok", tx_start_ok, e);
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    $display("BAD watchdog expired");
    report_and_stop;
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    bus(0, `OFS_RX_FIFO_START_ADDR, 0);
    chk("rx start", rd, 32'h600);
    bus(0, `OFS_FIFO_RAM_UPPER_BOUND, 0);
    chk("bound", rd, 32'h7fc);
    bus(0, `OFS_TX_START_WATERMARK, 0);
    chk("watermark", rd, 32'h0);
    chk("tx_region_last", tx_region_last, 32'h5fc);
    chk("rx_region_last", rx_region_last, 32'h7fc);
    chk("loaded", hash_tables_loaded, 32'h0);
    look(0, 6'd63, 0);
    $display("test reset done");
    bus(1, `OFS_FIFO_RAM_UPPER_BOUND, 32'h0);
    bus(0, `OFS_FIFO_RAM_UPPER_BOUND, 0);
    chk("bound", rd, 32'h7fc);
    bus(1, 6'h1c, 32'hffff_ffff);
    bus(0, 6'h1c, 0);
    chk("unmapped", rd, 32'h0);
    bus(1, `OFS_RX_FIFO_START_ADDR, 32'hffff_ffff);
    bus(0, `OFS_RX_FIFO_START_ADDR, 0);
    chk("rx start", rd, 32'h7fc);
    chk("tx_region_last", tx_region_last, 32'h7f8);
    bus(1, `OFS_RX_FIFO_START_ADDR, 32'h0);
    bus(0, `OFS_RX_FIFO_START_ADDR, 0);
    chk("rx start", rd, 32'h400);
    chk("rx_region_first", rx_region_first, 32'h400);
    chk("tx_region_last", tx_region_last, 32'h3fc);
    avs_byteenable <= 4'h1;
    bus(1, `OFS_RX_FIFO_START_ADDR, 32'hffff_ffff);
    avs_byteenable <= 4'h2;
    bus(1, `OFS_RX_FIFO_START_ADDR, 32'h0000_0200);
    avs_byteenable <= 4'hf;
    bus(0, `OFS_RX_FIFO_START_ADDR, 0);
    chk("rx start lanes", rd, 32'h6fc);
    bus(1, `OFS_RX_FIFO_START_ADDR, 32'h600);
    $display("test partition done");
    bus(1, `OFS_UNICAST_HASH_UPPER, uni[63:32]);
    bus(1, `OFS_UNICAST_HASH_LOWER, uni[31:0]);
    bus(1, `OFS_MULTICAST_HASH_UPPER, grp[63:32]);
    chk("loaded", hash_tables_loaded, 32'h0);
    bus(1, `OFS_MULTICAST_HASH_LOWER, grp[31:0]);
    bus(0, `OFS_UNICAST_HASH_UPPER, 0);
    chk("uni upper", rd, uni[63:32]);
    bus(0, `OFS_MULTICAST_HASH_LOWER, 0);
    chk("grp lower", rd, grp[31:0]);
    chk("loaded", hash_tables_loaded, 32'h1);
    for (int i = 0; i < 64; i++) begin
      look(0, 6'(i), uni[i]);
      look(1, 6'(i), grp[i]);
    end
    $display("test hash done");
    for (int s = 0; s < 4; s++) begin
      bus(1, `OFS_TX_START_WATERMARK, 32'(s));
      bus(0, `OFS_TX_START_WATERMARK, 0);
      chk("watermark", rd, 32'(s));
      tx(11'(thr[s] - 1), 0, 0);
      tx(11'(thr[s]), 0, 1);
      tx(11'h00a, 1, 1);
    end
    $display("test watermark done");
    bus(1, `OFS_RX_FIFO_START_ADDR, 32'h0);
    bus(1, `OFS_TX_START_WATERMARK, 32'h3);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk("loaded", hash_tables_loaded, 32'h0);
    bus(0, `OFS_RX_FIFO_START_ADDR, 0);
    chk("rx start", rd, 32'h600);
    bus(0, `OFS_TX_START_WATERMARK, 0);
    chk("watermark", rd, 32'h0);
    look(1, 6'd15, 0);
    $display("test reset again done");
    report_and_stop;
  end
endmodule
`default_nettype wire
